// >>> design/tdcp_pins.sv
// Discrete control and address pin logic of a 1553 terminal
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - RT standard status: low input sets flag
// - Input never alters subsystem flag config bit
// - BC trigger rising edge issues start
// - Enhanced BC wait instruction stalls until edge
// - Word monitor trigger rising edge starts monitor
// - Source 0 takes address from pins
// - Source 1 loads address from register 5
// - Respond only on odd address parity
// - Latch low means pins used transparently
// - Latch rising edge captures pins
// - Latch high: enhanced, enable, write reg 5
// - Select 0: active-low in-message indicator
// - Word monitor online holds indicator low
// - RT select 1: two-cycle reset pulse low
// - BC or monitor select 1: output high
// - Tag clock up to quarter rate sampled
// - Sleep disables receivers and transmitters
// - Transmit inhibit input shuts both channels
// - Inhibit outputs high when not transmitting
// - Clock selects choose frequency unless boot
module tdcp_pins
  import tdcp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Trigger and flag pin
  input  wire logic        subsystem_flag_in,
  input  wire logic        wait_for_trigger_instr,
  output logic             bc_start,
  output logic             wait_release,
  output logic             monitor_start,
  output logic             status_subsystem_flag,
  // Address pins
  input  wire logic [4:0]  terminal_address_pins,
  input  wire logic        terminal_address_parity_pin,
  input  wire logic        terminal_address_latch_in,
  output logic      [4:0]  terminal_address,
  output logic             address_parity_ok,
  // Protocol core state
  input  wire logic        alt_status_word,
  input  wire logic        message_active,
  input  wire logic        monitor_online,
  input  wire logic        reset_mode_cmd,
  input  wire logic        tx_active_a,
  input  wire logic        tx_active_b,
  output logic             in_message_indicator,
  // Transceiver controls
  input  wire logic        sleep_in,
  input  wire logic        transmit_inhibit_in,
  output logic             rx_enable,
  output logic             tx_enable_a,
  output logic             tx_enable_b,
  output logic             transmit_inhibit_out_a,
  output logic             transmit_inhibit_out_b,
  // Tag clock
  input  wire logic        tag_clock_in,
  output logic             tag_tick,
  // Boot and clock select straps
  input  wire logic        boot_terminal_busy_strap,
  input  wire logic [1:0]  clock_select_in,
  output logic      [4:0]  clock_mhz,
  output logic             status_busy,
  output logic             busy_rx_disable,
  output tdcp_mode_t       mode
);

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  tdcp_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  wire wr_cfg1 = req.wr && (req.addr == TDCP_REG_CFG1);
  wire wr_cfg3 = req.wr && (req.addr == TDCP_REG_CFG3);
  wire wr_cfg4 = req.wr && (req.addr == TDCP_REG_CFG4);
  wire wr_cfg5 = req.wr && (req.addr == TDCP_REG_CFG5);
  wire wr_cfg6 = req.wr && (req.addr == TDCP_REG_CFG6);
  wire wr_cfg7 = req.wr && (req.addr == TDCP_REG_CFG7);
  wire wr_mode = req.wr && (req.addr == TDCP_REG_MODE);

  // Config registers, whole words held as written
  logic [15:0] cfg1_r;        // Subsystem flag and trigger enable
  logic [15:0] cfg3_r;        // Enhanced mode
  logic [15:0] cfg4_r;        // Latch enable
  logic [15:0] cfg6_r;        // Address source
  logic [15:0] cfg7_r;        // Output select
  tdcp_mode_t  mode_r;        // Operating mode
  logic        boot_done_r;   // Strap already sampled

  wire trig_en  = cfg1_r[TDCP_TRGEN_BIT];
  wire addr_src = cfg6_r[TDCP_ADSRC_BIT];
  wire out_sel  = cfg7_r[TDCP_OSEL_BIT];
  wire sw_latch = cfg3_r[TDCP_ENH_BIT] && cfg4_r[TDCP_LATEN_BIT];

  // ----------------------------------------------------------------
  // Configuration writes
  // ----------------------------------------------------------------
  // Config bit 8 only ever holds what software wrote
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg1_r <= TDCP_CFG_RST;
      cfg3_r <= TDCP_CFG_RST;
      cfg4_r <= TDCP_CFG_RST;
      cfg6_r <= TDCP_CFG_RST;
      cfg7_r <= TDCP_CFG_RST;
    end
    else
    begin
      if (wr_cfg1) cfg1_r <= req.wdata;
      if (wr_cfg3) cfg3_r <= req.wdata;
      if (wr_cfg4) cfg4_r <= req.wdata;
      if (wr_cfg6) cfg6_r <= req.wdata;
      if (wr_cfg7) cfg7_r <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Boot strap and mode
  // ----------------------------------------------------------------
  // Strap caught on the first clock after reset release, not in reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_r      <= TDCP_MODE_BC;
      boot_done_r <= 1'b0;
    end
    else if (!boot_done_r)
    begin
      boot_done_r <= 1'b1;
      if (boot_terminal_busy_strap)
        mode_r <= TDCP_MODE_RT;
    end
    else if (wr_mode)
    begin
      mode_r <= tdcp_mode_t'(req.wdata[2:0]);
    end
  end

  // Busy bits take the strap once, at boot; software clears them
  logic busy_r;
  always_ff @(posedge clk)
  begin
    if (srst)
      busy_r <= 1'b0;
    else if (!boot_done_r)
      busy_r <= boot_terminal_busy_strap;
    else if (wr_mode)
      busy_r <= req.wdata[3];
  end

  assign mode            = mode_r;
  assign status_busy     = busy_r;
  assign busy_rx_disable = busy_r;

  // ----------------------------------------------------------------
  // Clock select
  // ----------------------------------------------------------------
  logic [4:0] mhz_sel;
  always_comb
  begin
    case (clock_select_in)
      2'h0:    mhz_sel = TDCP_MHZ_SEL00;
      2'h1:    mhz_sel = TDCP_MHZ_SEL01;
      2'h2:    mhz_sel = TDCP_MHZ_SEL10;
      default: mhz_sel = TDCP_MHZ_SEL11;
    endcase
  end

  // Selects ignored when booting into RT; default rate kept then
  logic [4:0] clock_mhz_r;
  always_ff @(posedge clk)
  begin
    if (srst)
      clock_mhz_r <= TDCP_MHZ_SEL00;
    else if (!boot_terminal_busy_strap)
      clock_mhz_r <= mhz_sel;
  end
  assign clock_mhz = clock_mhz_r;

  // ----------------------------------------------------------------
  // Trigger edge detection
  // ----------------------------------------------------------------
  // Input is synchronous; one stage suffices for the edge.
  // Driver holds it high four clocks, so no edge is missed.
  // Follows the pin in reset too, so no false edge at release
  logic trig_q_r;
  always_ff @(posedge clk)
    trig_q_r <= subsystem_flag_in;
  wire trig_rise = subsystem_flag_in && !trig_q_r;

  // Start and release pulses, one cycle each
  logic bc_start_r;
  logic wait_rel_r;
  logic mon_start_r;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bc_start_r  <= 1'b0;
      wait_rel_r  <= 1'b0;
      mon_start_r <= 1'b0;
    end
    else
    begin
      bc_start_r  <= trig_rise && trig_en
                     && (mode_r == TDCP_MODE_BC);
      wait_rel_r  <= trig_rise && wait_for_trigger_instr
                     && (mode_r == TDCP_MODE_EBC);
      mon_start_r <= trig_rise && trig_en
                     && (mode_r == TDCP_MODE_WMON);
    end
  end
  assign bc_start      = bc_start_r;
  assign wait_release  = wait_rel_r;
  assign monitor_start = mon_start_r;

  // Status flag: config bit or low input, standard status only
  logic ssf_r;
  always_ff @(posedge clk)
  begin
    if (srst)
      ssf_r <= 1'b0;
    else
      ssf_r <= cfg1_r[TDCP_SSF_BIT]
               || ((mode_r == TDCP_MODE_RT) && !alt_status_word
                   && !subsystem_flag_in);
  end
  assign status_subsystem_flag = ssf_r;

  // ----------------------------------------------------------------
  // Terminal address selection
  // ----------------------------------------------------------------
  tdcp_addr_t pins;
  assign pins = '{addr: terminal_address_pins,
                  par:  terminal_address_parity_pin};

  logic       lat_q_r;   // Previous latch input level
  tdcp_addr_t held_r;    // Latched address and parity
  wire lat_rise = terminal_address_latch_in && !lat_q_r;

  // Capture on latch edge or on a register 5 write when armed
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lat_q_r <= terminal_address_latch_in;
      held_r  <= '0;
    end
    else
    begin
      lat_q_r <= terminal_address_latch_in;
      if (wr_cfg5 && addr_src)
        held_r <= '{addr: req.wdata[5:1], par: req.wdata[0]};
      else if (wr_cfg5 && sw_latch && terminal_address_latch_in)
        held_r <= pins;
      else if (lat_rise && !addr_src)
        held_r <= pins;
    end
  end

  // Pins follow through while latch is low and source is pins
  tdcp_addr_t eff_addr;
  assign eff_addr = (!addr_src && !terminal_address_latch_in)
                    ? pins : held_r;

  logic [4:0] addr_r;
  logic       par_ok_r;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      addr_r   <= 5'h00;
      par_ok_r <= 1'b0;
    end
    else
    begin
      addr_r   <= eff_addr.addr;
      par_ok_r <= ^{eff_addr.addr, eff_addr.par};
    end
  end
  assign terminal_address  = addr_r;
  assign address_parity_ok = par_ok_r;

  // ----------------------------------------------------------------
  // Shared in-message / reset pulse output
  // ----------------------------------------------------------------
  logic [1:0] rst_cnt_r;  // Remaining low cycles of reset pulse
  always_ff @(posedge clk)
  begin
    if (srst)
      rst_cnt_r <= 2'h0;
    else if (reset_mode_cmd && out_sel && (mode_r == TDCP_MODE_RT))
      rst_cnt_r <= TDCP_RST_PULSE;
    else if (rst_cnt_r != 2'h0)
      rst_cnt_r <= rst_cnt_r - 2'h1;
  end

  logic ind_nxt;
  always_comb
  begin
    if (!out_sel)
    begin
      if (mode_r == TDCP_MODE_WMON)
        ind_nxt = !monitor_online;
      else
        ind_nxt = !message_active;
    end
    else if (mode_r == TDCP_MODE_RT)
      ind_nxt = (rst_cnt_r == 2'h0);
    else
      ind_nxt = 1'b1;
  end

  logic ind_r;
  always_ff @(posedge clk)
  begin
    if (srst)
      ind_r <= 1'b1;
    else
      ind_r <= ind_nxt;
  end
  assign in_message_indicator = ind_r;

  // ----------------------------------------------------------------
  // Transceiver enables and inhibits
  // ----------------------------------------------------------------
  logic rx_en_r;
  logic txa_en_r;
  logic txb_en_r;
  logic inha_r;
  logic inhb_r;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rx_en_r  <= 1'b0;
      txa_en_r <= 1'b0;
      txb_en_r <= 1'b0;
      inha_r   <= 1'b1;
      inhb_r   <= 1'b1;
    end
    else
    begin
      rx_en_r  <= !sleep_in;
      txa_en_r <= !sleep_in && !transmit_inhibit_in;
      txb_en_r <= !sleep_in && !transmit_inhibit_in;
      inha_r   <= !(tx_active_a && !transmit_inhibit_in);
      inhb_r   <= !(tx_active_b && !transmit_inhibit_in);
    end
  end
  assign rx_enable              = rx_en_r;
  assign tx_enable_a            = txa_en_r;
  assign tx_enable_b            = txb_en_r;
  assign transmit_inhibit_out_a = inha_r;
  assign transmit_inhibit_out_b = inhb_r;

  // ----------------------------------------------------------------
  // Tag clock sampling
  // ----------------------------------------------------------------
  // Two-stage sync then edge; fine up to one quarter of clk
  logic tag_s1_r;
  logic tag_s2_r;
  logic tag_s3_r;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tag_s1_r <= 1'b0;
      tag_s2_r <= 1'b0;
      tag_s3_r <= 1'b0;
    end
    else
    begin
      tag_s1_r <= tag_clock_in;
      tag_s2_r <= tag_s1_r;
      tag_s3_r <= tag_s2_r;
    end
  end
  assign tag_tick = tag_s2_r && !tag_s3_r;

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb
  begin
    case (req.addr)
      TDCP_REG_CFG1:   rd_mux = cfg1_r;
      TDCP_REG_CFG3:   rd_mux = cfg3_r;
      TDCP_REG_CFG4:   rd_mux = cfg4_r;
      TDCP_REG_CFG6:   rd_mux = cfg6_r;
      TDCP_REG_CFG7:   rd_mux = cfg7_r;
      TDCP_REG_MODE:   rd_mux = {12'h000, busy_r, 3'(mode_r)};
      TDCP_REG_STATUS: rd_mux = {4'h0, par_ok_r, addr_r, clock_mhz_r,
                                 ind_r};
      default:         rd_mux = 16'h0000;
    endcase
  end

  // Read data stands the cycle after the strobe only
  logic [15:0] rdata_r;
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_r <= 16'h0000;
    else if (req.rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= 16'h0000;
  end
  assign reg_rdata = rdata_r;

endmodule : tdcp_pins

`default_nettype wire

// >>> pkg/tdcp_pkg.sv
// Package for the terminal discrete control pin block
package tdcp_pkg;

  // ----------------------------------------------------------------
  // Register map (word offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] TDCP_REG_CFG1   = 4'h1;  // Subsystem flag, trigger en
  localparam logic [3:0] TDCP_REG_CFG3   = 4'h3;  // Enhanced mode
  localparam logic [3:0] TDCP_REG_CFG4   = 4'h4;  // Latch-with-reg5 enable
  localparam logic [3:0] TDCP_REG_CFG5   = 4'h5;  // Software address write
  localparam logic [3:0] TDCP_REG_CFG6   = 4'h6;  // Address source select
  localparam logic [3:0] TDCP_REG_CFG7   = 4'h7;  // Shared output select
  localparam logic [3:0] TDCP_REG_MODE   = 4'h8;  // Operating mode, own choice
  localparam logic [3:0] TDCP_REG_STATUS = 4'h9;  // Live state, read only

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TDCP_SSF_BIT     = 8;   // Subsystem flag config bit
  localparam int TDCP_TRGEN_BIT   = 7;   // External trigger enable
  localparam int TDCP_ENH_BIT     = 15;  // Enhanced mode
  localparam int TDCP_LATEN_BIT   = 3;   // Latch with register 5
  localparam int TDCP_ADSRC_BIT   = 5;   // Address source select
  localparam int TDCP_OSEL_BIT    = 0;   // Shared output select

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] TDCP_CFG_RST    = 16'h0000;
  localparam logic [1:0]  TDCP_RST_PULSE  = 2'h2;  // Reset pulse, cycles
  localparam int          TDCP_TAG_DIV    = 4;     // Tag clock max ratio

  // Clock select codes, values in MHz
  localparam logic [4:0] TDCP_MHZ_SEL00 = 5'h0A;
  localparam logic [4:0] TDCP_MHZ_SEL01 = 5'h14;
  localparam logic [4:0] TDCP_MHZ_SEL10 = 5'h0C;
  localparam logic [4:0] TDCP_MHZ_SEL11 = 5'h10;

  // Operating modes
  typedef enum logic [2:0] {
    TDCP_MODE_BC,
    TDCP_MODE_EBC,
    TDCP_MODE_RT,
    TDCP_MODE_WMON,
    TDCP_MODE_SMON
  } tdcp_mode_t;

  // Address plus parity bundle
  typedef struct packed {
    logic [4:0] addr;
    logic       par;
  } tdcp_addr_t;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tdcp_req_t;

endpackage : tdcp_pkg

// >>> sim/tb_top.sv
// Self-checking bench for the terminal discrete control pin block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import tdcp_pkg::*;
  // ------------------------------------------------
  // Design signals, bench inputs set at time zero, far model drives the rest
  // ------------------------------------------------
  logic        clk = 1'b0, srst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, tag_run = 1'b0;
  logic        subsystem_flag_in = 1'b0, wait_for_trigger_instr = 1'b0;
  logic        alt_status_word = 1'b0, message_active = 1'b0;
  logic        monitor_online = 1'b0, reset_mode_cmd = 1'b0;
  logic        sleep_in = 1'b0, transmit_inhibit_in = 1'b0;
  logic        terminal_address_latch_in = 1'b0;
  logic        terminal_address_parity_pin = 1'b0;
  logic        boot_terminal_busy_strap = 1'b0;
  logic [1:0]  clock_select_in = 2'h0;
  logic [4:0]  terminal_address_pins = 5'h00, terminal_address, clock_mhz;
  logic        bc_start, wait_release, monitor_start, status_subsystem_flag;
  logic        address_parity_ok, in_message_indicator, rx_enable;
  logic        tx_enable_a, tx_enable_b, tag_tick, status_busy;
  logic        transmit_inhibit_out_a, transmit_inhibit_out_b;
  logic        busy_rx_disable, tag_clock_in, tx_active_a, tx_active_b;
  tdcp_mode_t  mode;
  // Bench state
  int          n_errors = 0, checked = 0;
  int          n_bc = 0, n_wr = 0, n_mon = 0, n_low = 0;
  int          n_rise = 0, n_tick = 0, b0, w0, m0;
  logic        tag_q = 1'b0;
  logic [31:0] seed = 32'h63FD;
  logic [4:0]  a0;

  tdcp_pins uut (.*);
  tdcp_far_model u_far (.*);
  always #20 clk = ~clk;

  // Count pulses and edges as issued
  always @(posedge clk)
  begin
    n_bc   += int'(bc_start);
    n_wr   += int'(wait_release);
    n_mon  += int'(monitor_start);
    n_low  += int'(in_message_indicator === 1'b0);
    n_rise += int'(tag_clock_in && !tag_q);
    n_tick += int'(tag_tick);
    tag_q  = tag_clock_in;
  end

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Pulse pattern weighted bc 1, wait 4, monitor 16
  function automatic int trig_exp(input int m, input int e);
    if (e == 0)
      return 0;
    return (m == 0) ? 1 : (m == 1) ? 4 : (m == 3) ? 16 : 0;
  endfunction : trig_exp
  function automatic logic [4:0] mhz_of(input logic [1:0] s);
    return s[1] ? (s[0] ? 5'h10 : 5'h0C) : (s[0] ? 5'h14 : 5'h0A);
  endfunction : mhz_of
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
    @(posedge clk);  // Stimulus resumes at a rising edge
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk) chk(reg_rdata, exp);
  endtask : rdc
  task automatic trig();
    @(posedge clk) subsystem_flag_in <= 1'b1;
    cyc(4);
    subsystem_flag_in <= 1'b0;
    cyc(3);
  endtask : trig
  task automatic do_reset(input logic strap);
    @(posedge clk);
    srst <= 1'b1;
    boot_terminal_busy_strap <= strap;
    cyc(20);
    srst <= 1'b0;
    cyc(2);
  endtask : do_reset
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial
  begin
    do_reset(1'b0);
    for (int a = 1; a < 9; a++)
      rdc(4'(a), 16'h0000);
    rdc(TDCP_REG_STATUS, 16'h0015);
    wr(4'hF, 16'hFFFF);
    rdc(4'hF, 16'h0000);
    tdone("reset");
    // Every mode, trigger enabled then disabled
    for (int e = 1; e >= 0; e--)
      for (int m = 0; m < 5; m++)
      begin
        wr(TDCP_REG_MODE, 16'(m));
        wr(TDCP_REG_CFG1, (e != 0) ? 16'h0080 : 16'h0000);
        wait_for_trigger_instr <= (e != 0);
        b0 = n_bc;
        w0 = n_wr;
        m0 = n_mon;
        trig();
        @(negedge clk) chk(16'((n_bc - b0) + 4 * (n_wr - w0)
          + 16 * (n_mon - m0)), 16'(trig_exp(m, e)));
      end
    tdone("trigger");
    wr(TDCP_REG_MODE, 16'h0002);
    cyc(3);
    @(negedge clk) chk(16'(status_subsystem_flag), 16'h0001);
    rdc(TDCP_REG_CFG1, 16'h0000);
    alt_status_word <= 1'b1;
    cyc(3);
    @(negedge clk) chk(16'(status_subsystem_flag), 16'h0000);
    wr(TDCP_REG_CFG1, 16'h0100);
    subsystem_flag_in <= 1'b1;
    rdc(TDCP_REG_CFG1, 16'h0100);
    alt_status_word <= 1'b0;
    tdone("flag");
    // Reset pulse, then indicator in BC and monitor
    wr(TDCP_REG_CFG7, 16'h0001);
    b0 = n_low;
    cyc(1);
    reset_mode_cmd <= 1'b1;
    cyc(1);
    reset_mode_cmd <= 1'b0;
    cyc(8);
    @(negedge clk) chk(16'(n_low - b0), 16'h0002);
    wr(TDCP_REG_MODE, 16'h0000);
    message_active <= 1'b1;
    cyc(3);
    @(negedge clk) chk(16'(in_message_indicator), 16'h0001);
    wr(TDCP_REG_CFG7, 16'h0000);
    cyc(2);
    @(negedge clk) chk(16'(in_message_indicator), 16'h0000);
    message_active <= 1'b0;
    cyc(3);
    wr(TDCP_REG_MODE, 16'h0003);
    monitor_online <= 1'b1;
    cyc(3);
    @(negedge clk) chk(16'(in_message_indicator), 16'h0000);
    monitor_online <= 1'b0;
    cyc(3);
    tdone("indicator");
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      terminal_address_pins       <= seed[4:0];
      terminal_address_parity_pin <= seed[5];
      cyc(3);
      @(negedge clk) chk(16'(terminal_address), 16'(seed[4:0]));
      @(negedge clk) chk(16'(address_parity_ok), 16'(^seed[5:0]));
    end
    a0 = ~seed[4:0];
    terminal_address_latch_in <= 1'b1;
    cyc(2);
    terminal_address_pins <= a0;
    cyc(3);
    @(negedge clk) chk(16'(terminal_address), 16'(seed[4:0]));
    // Software latch of pins with data ignored, then address from register 5 data
    wr(TDCP_REG_CFG3, 16'h8000);
    wr(TDCP_REG_CFG4, 16'h0008);
    wr(TDCP_REG_CFG5, 16'h003F);
    cyc(2);
    @(negedge clk) chk(16'(terminal_address), 16'(a0));
    wr(TDCP_REG_CFG6, 16'h0020);
    wr(TDCP_REG_CFG5, 16'h002B);
    cyc(2);
    @(negedge clk) chk(16'(terminal_address), 16'h0015);
    @(negedge clk) chk(16'(address_parity_ok), 16'h0000);
    tdone("address");
    sleep_in <= 1'b1;
    cyc(2);
    @(negedge clk) chk(16'(rx_enable), 16'h0000);
    sleep_in <= 1'b0;
    transmit_inhibit_in <= 1'b1;
    cyc(2);
    @(negedge clk) chk(16'({tx_enable_a, tx_enable_b, transmit_inhibit_out_a,
      transmit_inhibit_out_b}), 16'h0003);
    transmit_inhibit_in <= 1'b0;
    for (int i = 0; i < 16 && tx_active_a !== 1'b1; i++)
      @(negedge clk);
    cyc(1);
    @(negedge clk) chk(16'(transmit_inhibit_out_a), 16'h0000);
    b0 = n_tick;
    w0 = n_rise;
    tag_run <= 1'b1;
    cyc(40);
    tag_run <= 1'b0;
    cyc(8);
    @(negedge clk) chk(16'(n_tick - b0), 16'(n_rise - w0));
    tdone("transceiver");
    for (int i = 0; i < 4; i++)
    begin
      clock_select_in <= 2'(i);
      cyc(2);
      @(negedge clk) chk(16'(clock_mhz), 16'(mhz_of(2'(i))));
    end
    // Boot strap: selects ignored, comes up busy
    clock_select_in <= 2'h1;
    do_reset(1'b1);
    @(negedge clk) chk(16'({mode, status_busy, busy_rx_disable, clock_mhz}),
      16'({TDCP_MODE_RT, 2'h3, 5'h0A}));
    rdc(TDCP_REG_MODE, 16'h000A);
    tdone("boot");
    finish_test();
  end

  // Watchdog, far beyond the expected run length
  initial
  begin
    #400000;
    n_errors++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

// >>> sim/tdcp_far_model.sv
// Far side model: tag clock source and transmitter activity
`timescale 1ns/1ns
`default_nettype none
module tdcp_far_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Bench control
  input  wire logic tag_run,
  // Toward the block
  output logic      tag_clock_in,
  output logic      tx_active_a,
  output logic      tx_active_b
);
  // ------------------------------------------------
  // Free counter paces tag clock and bursts
  // ------------------------------------------------
  logic [3:0] cnt_r;  // Phase counter
  always_ff @(posedge clk)
  begin
    cnt_r <= srst ? 4'h0 : cnt_r + 4'h1;
    // Quarter rate at most, still while idle
    tag_clock_in <= tag_run & cnt_r[1];
  end
  // A and B bursts never overlap
  assign tx_active_a = cnt_r[3:2] == 2'h1;
  assign tx_active_b = cnt_r[3:2] == 2'h3;
endmodule : tdcp_far_model
`default_nettype wire

// >>> sim/tdcp_pins_monitor.sv
// Assertion checker for the terminal discrete control pin block
`timescale 1ns/1ns
`default_nettype none
module tdcp_pins_monitor
  import tdcp_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // Trigger and flag pin
  input wire logic       subsystem_flag_in,
  input wire logic       wait_for_trigger_instr,
  input wire logic       alt_status_word,
  input wire logic       bc_start,
  input wire logic       wait_release,
  input wire logic       monitor_start,
  input wire logic       status_subsystem_flag,
  // Shared output
  input wire logic       message_active,
  input wire logic       in_message_indicator,
  // Transceiver controls
  input wire logic       sleep_in,
  input wire logic       transmit_inhibit_in,
  input wire logic       tx_active_a,
  input wire logic       rx_enable,
  input wire logic       tx_enable_a,
  input wire logic       tx_enable_b,
  input wire logic       transmit_inhibit_out_a,
  input wire logic       transmit_inhibit_out_b,
  // Straps
  input wire logic       boot_terminal_busy_strap,
  input wire logic [1:0] clock_select_in,
  input wire logic [4:0] clock_mhz,
  input wire tdcp_mode_t mode
);
  // ------------------------------------------------
  // Helper logic
  // ------------------------------------------------
  wire logic [4:0] mhz_nxt;  // Frequency the selects ask for
  logic      [4:0] mhz_r;    // Same, one cycle late
  assign mhz_nxt = clock_select_in[1]
    ? (clock_select_in[0] ? TDCP_MHZ_SEL11 : TDCP_MHZ_SEL10)
    : (clock_select_in[0] ? TDCP_MHZ_SEL01 : TDCP_MHZ_SEL00);
  always_ff @(posedge clk)
    mhz_r <= mhz_nxt;

  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_bc_cause: assert property (
    bc_start |-> $past(subsystem_flag_in) && !$past(subsystem_flag_in, 2)
      && $past(mode) == TDCP_MODE_BC)
    else $error("bc start without trigger edge");
  a_wait_go: assert property (
    ($rose(subsystem_flag_in) && wait_for_trigger_instr
      && mode == TDCP_MODE_EBC) |=> wait_release)
    else $error("wait not released on trigger edge");
  a_wait_hold: assert property (
    wait_release |-> $past(subsystem_flag_in)
      && !$past(subsystem_flag_in, 2) && $past(wait_for_trigger_instr))
    else $error("wait released without trigger edge");
  a_mon_cause: assert property (
    monitor_start |-> $past(subsystem_flag_in)
      && $past(mode) == TDCP_MODE_WMON)
    else $error("monitor start without cause");
  a_flag_force: assert property (
    (mode == TDCP_MODE_RT && !alt_status_word && !subsystem_flag_in)
      |=> status_subsystem_flag)
    else $error("status flag not forced by pin");
  // In BC a low output only ever means a message
  a_bc_indicator: assert property (
    (mode == TDCP_MODE_BC && !in_message_indicator) |-> $past(message_active))
    else $error("indicator low without message");
  a_sleep_off: assert property (
    sleep_in |=> !rx_enable && !tx_enable_a && !tx_enable_b)
    else $error("transceiver awake in sleep");
  a_inhibit_all: assert property (
    transmit_inhibit_in |=> !tx_enable_a && !tx_enable_b
      && transmit_inhibit_out_a && transmit_inhibit_out_b)
    else $error("transmit not shut down");
  a_idle_inhibit: assert property (
    !tx_active_a |=> transmit_inhibit_out_a)
    else $error("inhibit low while idle");
  a_clock_pick: assert property (
    !boot_terminal_busy_strap |=> clock_mhz == mhz_r)
    else $error("clock frequency not as selected");

  c_bc: cover property (bc_start);
  c_wait: cover property (wait_release);
  c_mon: cover property (monitor_start);
endmodule : tdcp_pins_monitor

bind tdcp_pins tdcp_pins_monitor u_mon (.*);
`default_nettype wire
